// ==== rtl/tfe_map.vh ====
// register map, field positions and codes for the tape formatter error flags
`ifndef TFE_MAP_VH
`define TFE_MAP_VH

// register addresses on the drive control bus (5-bit select)
`define TFE_ADDR_W          5
`define TFE_A_CS1           5'h00
`define TFE_A_STAT          5'h01
`define TFE_A_ERR           5'h02
`define TFE_A_MNT           5'h03
`define TFE_A_ATTN          5'h04
`define TFE_A_FC            5'h05
`define TFE_A_CS2           5'h06
`define TFE_A_TC            5'h09
// error flag bit positions
`define TFE_B_SKEW          10
`define TFE_B_FRAME         9
`define TFE_B_GAP           8
`define TFE_B_LONGCHK       7
`define TFE_B_UNCORR        6
`define TFE_B_DATPAR        5
`define TFE_B_FORMAT        4
`define TFE_B_CTLPAR        3
`define TFE_B_REFUSED       2
`define TFE_B_BADREG        1
`define TFE_B_BADFN         0
`define TFE_NFLAG           11
// first control/status register fields
`define TFE_CS1_GO          0
`define TFE_FN_LO           1
`define TFE_FN_HI           5
// second control/status register parity-test bit
`define TFE_CS2_PTEST       4
// tape control register format code field and the one format implemented
`define TFE_FMT_LO          4
`define TFE_FMT_HI          7
`define TFE_FMT_OK          4'hc
// drive status bits and the attention clear bit
`define TFE_ST_TMARK        2
`define TFE_ST_READY        7
`define TFE_ST_ERR          14
`define TFE_ST_ATTN         15
`define TFE_ATTN_CLR        0
// implemented function codes
`define TFE_FN_NOP          5'h00
`define TFE_FN_CLR          5'h04
`define TFE_FN_SPF          5'h0c
`define TFE_FN_SPR          5'h0d
`define TFE_FN_WR           5'h18
`define TFE_FN_RDF          5'h1c
`define TFE_ZERO16          16'h0000
`define TFE_ZERO11          11'h000
`define TFE_ONE11           11'h001

`endif

// ==== rtl/tfe_flag_bank.v ====
// bank of sticky error flags, set wins over clear
`timescale 1ns/1ps
`default_nettype none
`include "tfe_map.vh"

module tfe_flag_bank
(
    // clock and reset
    input  wire                   clk_sys,
    input  wire                   rst_b,
    // events and clear
    input  wire [`TFE_NFLAG-1:0]  set_evt,
    input  wire                   clr,
    // flag state
    output wire [`TFE_NFLAG-1:0]  flags
);
    genvar i;
    generate
        for (i = 0; i < `TFE_NFLAG; i = i + 1)
        begin : g_flag
            reg flag_r;
            always @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                    flag_r <= 1'b0;
                else if (set_evt[i])
                    flag_r <= 1'b1;
                else if (clr)
                    flag_r <= 1'b0;
            end
            assign flags[i] = flag_r;
        end
    endgenerate
endmodule // tfe_flag_bank

`default_nettype wire

// ==== rtl/tfe_error_flags.v ====
// error register bits 10..0 with control-bus register access
//
// Contract
// - PE mode: correctable skew sets the skew/mark flag, warning only.
// - NRZ mode: malformed filemark pattern sets the skew/mark flag.
// - Malformed filemark also asserts tape-mark status in drive status.
// - Space ending with nonzero frame counter sets frame count fault.
// - Run still high after end-of-block sets frame count fault.
// - Characters in first half of gap set nonstandard gap flag.
// - PE mode: bad preamble or postamble sets format/longcheck flag.
// - NRZ mode: longitudinal check mismatch sets format/longcheck flag.
// - PE read: dead tracks, parity without dead tracks, skew overflow.
// - NRZ read: vertical parity error or late data sets that flag.
// - Data line parity error during write sets data parity flag.
// - Parity-test bit forces both data and control parity flags.
// - Data transfer with unimplemented format code sets format fault.
// - Format fault stops motion, raises exception, end-of-block, ready.
// - Control line parity error on register write sets its flag.
// - Control parity error lets write finish but suppresses go.
// - Writes while go refused except maintenance and attention.
// - Access to nonexistent register sets bad register flag.
// - Nonexistent register read returns zeros, modifies nothing.
// - Go with unimplemented function sets bad function flag.
// - Flags read-only, cleared by drive clear or bus init.
// - Class A and class B error summaries are reported.
`timescale 1ns/1ps
`default_nettype none
`include "tfe_map.vh"

module tfe_error_flags
(
    // clock and reset
    input  wire                    clk_sys,
    input  wire                    rst_b,
    // control bus register access
    input  wire [`TFE_ADDR_W-1:0]  reg_addr,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    input  wire [15:0]             reg_wdata,
    input  wire                    reg_ctl_par_err,
    output reg  [15:0]             reg_rdata,
    // bus init and run line
    input  wire                    bus_init,
    input  wire                    run_req,
    // datapath condition pulses
    input  wire                    pe_mode,
    input  wire                    pe_skew_corr,
    input  wire                    nrz_bad_mark,
    input  wire                    space_done,
    input  wire                    frame_cnt_zero,
    input  wire                    xfer_done,
    input  wire                    gap_chars_seen,
    input  wire                    pe_bad_amble,
    input  wire                    nrz_lrc_mismatch,
    input  wire                    pe_multi_dead,
    input  wire                    pe_par_no_dead,
    input  wire                    pe_skew_ovf,
    input  wire                    nrz_vert_par,
    input  wire                    nrz_late_data,
    input  wire                    data_par_err,
    input  wire                    xfer_busy,
    input  wire                    write_op,
    input  wire                    read_op,
    input  wire                    op_end,
    // drive control outputs
    output wire                    go_bit,
    output wire [4:0]              func_code,
    output wire                    motion_inhibit,
    output reg                     exception_signal,
    output reg                     end_of_block,
    output reg                     drive_ready,
    output reg                     attention_flag,
    output wire                    class_a_err,
    output wire                    class_b_err,
    output wire [`TFE_NFLAG-1:0]   drive_error_flags
);
    // ==========================================================
    // registers
    reg  [15:0] cs1_r;
    reg  [15:0] cs2_r;
    reg  [15:0] tc_r;
    reg  [15:0] fc_r;
    reg  [15:0] mnt_r;
    reg         tape_mark_r;
    reg         fmt_hold_r;
    reg  [`TFE_NFLAG-1:0] set_evt;
    wire [`TFE_NFLAG-1:0] flags;
    wire        drive_clr;
    wire        clr_all;
    wire        known;
    wire        wr_ok;
    wire        wr_refused;
    wire [4:0]  wr_fn;
    wire        fn_known;
    wire        start_xfer;
    wire        bad_fmt;
    wire        par_test;
    reg  [15:0] stat_word;

    assign go_bit    = cs1_r[`TFE_CS1_GO];
    assign func_code = cs1_r[`TFE_FN_HI:`TFE_FN_LO];
    assign par_test  = cs2_r[`TFE_CS2_PTEST];
    assign drive_error_flags = flags;
    // decoded register addresses
    assign known = (reg_addr == `TFE_A_CS1) || (reg_addr == `TFE_A_STAT)
                || (reg_addr == `TFE_A_ERR) || (reg_addr == `TFE_A_MNT)
                || (reg_addr == `TFE_A_ATTN) || (reg_addr == `TFE_A_FC)
                || (reg_addr == `TFE_A_CS2) || (reg_addr == `TFE_A_TC);
    // refuse writes while go, except maintenance and attention
    assign wr_refused = reg_wr && known && go_bit
                     && (reg_addr != `TFE_A_MNT)
                     && (reg_addr != `TFE_A_ATTN);
    assign wr_ok = reg_wr && known && !wr_refused;
    assign wr_fn = reg_wdata[`TFE_FN_HI:`TFE_FN_LO];
    assign fn_known = (wr_fn == `TFE_FN_NOP) || (wr_fn == `TFE_FN_CLR)
                   || (wr_fn == `TFE_FN_SPF) || (wr_fn == `TFE_FN_SPR)
                   || (wr_fn == `TFE_FN_WR) || (wr_fn == `TFE_FN_RDF);
    wire cs1_go_wr = wr_ok && (reg_addr == `TFE_A_CS1)
                  && reg_wdata[`TFE_CS1_GO] && !reg_ctl_par_err;
    assign drive_clr = cs1_go_wr && (wr_fn == `TFE_FN_CLR);
    assign clr_all   = drive_clr || bus_init;
    assign start_xfer = cs1_go_wr && ((wr_fn == `TFE_FN_WR)
                     || (wr_fn == `TFE_FN_RDF));
    assign bad_fmt = tc_r[`TFE_FMT_HI:`TFE_FMT_LO] != `TFE_FMT_OK;

    // ==========================================================
    // error events
    always @*
    begin
        set_evt = `TFE_ZERO11;
        // a drive clear in the same cycle loses to these sets
        set_evt[`TFE_B_SKEW]    = (pe_mode && pe_skew_corr)
                               || (!pe_mode && nrz_bad_mark);
        set_evt[`TFE_B_FRAME]   = (space_done && !frame_cnt_zero)
                               || (end_of_block && run_req);
        set_evt[`TFE_B_GAP]     = xfer_done && gap_chars_seen;
        set_evt[`TFE_B_LONGCHK] = (pe_mode && pe_bad_amble)
                               || (!pe_mode && nrz_lrc_mismatch);
        set_evt[`TFE_B_UNCORR]  = read_op && (pe_mode
                               ? (pe_multi_dead || pe_par_no_dead
                                  || pe_skew_ovf)
                               : (nrz_vert_par || nrz_late_data));
        set_evt[`TFE_B_DATPAR]  = (write_op && data_par_err)
                               || par_test;
        set_evt[`TFE_B_FORMAT]  = start_xfer && bad_fmt;
        set_evt[`TFE_B_CTLPAR]  = (reg_wr && reg_ctl_par_err)
                               || par_test;
        set_evt[`TFE_B_REFUSED] = wr_refused;
        set_evt[`TFE_B_BADREG]  = (reg_wr || reg_rd) && !known;
        set_evt[`TFE_B_BADFN]   = cs1_go_wr && !fn_known;
    end

    tfe_flag_bank u_flags
    (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .set_evt (set_evt),
        .clr     (clr_all),
        .flags   (flags)
    );

    // class summaries
    assign class_a_err = flags[`TFE_B_FRAME] | flags[`TFE_B_GAP]
                       | flags[`TFE_B_LONGCHK] | flags[`TFE_B_UNCORR]
                       | flags[`TFE_B_DATPAR] | flags[`TFE_B_CTLPAR]
                       | flags[`TFE_B_REFUSED] | flags[`TFE_B_BADREG];
    assign class_b_err = flags[`TFE_B_FORMAT] | flags[`TFE_B_BADFN];
    assign motion_inhibit = fmt_hold_r;

    // ==========================================================
    // register writes
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cs1_r <= `TFE_ZERO16;
            cs2_r <= `TFE_ZERO16;
            tc_r  <= `TFE_ZERO16;
            fc_r  <= `TFE_ZERO16;
            mnt_r <= `TFE_ZERO16;
        end
        else if (bus_init)
        begin
            cs1_r <= `TFE_ZERO16;
            cs2_r <= `TFE_ZERO16;
            tc_r  <= `TFE_ZERO16;
            fc_r  <= `TFE_ZERO16;
            mnt_r <= `TFE_ZERO16;
        end
        else
        begin
            if (wr_ok && (reg_addr == `TFE_A_CS1))
            begin
                cs1_r <= reg_wdata;
                // drive clear and a format fault both leave go low
                cs1_r[`TFE_CS1_GO] <= cs1_go_wr && !drive_clr
                                   && !(start_xfer && bad_fmt);
            end
            else if (op_end)
                cs1_r[`TFE_CS1_GO] <= 1'b0;
            if (wr_ok && (reg_addr == `TFE_A_CS2))
                cs2_r <= reg_wdata;
            if (wr_ok && (reg_addr == `TFE_A_TC))
                tc_r <= reg_wdata;
            if (wr_ok && (reg_addr == `TFE_A_FC))
                fc_r <= reg_wdata;
            if (wr_ok && (reg_addr == `TFE_A_MNT))
                mnt_r <= reg_wdata;
        end
    end

    // ==========================================================
    // format fault sequencing and drive status
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fmt_hold_r       <= 1'b0;
            exception_signal <= 1'b0;
            end_of_block     <= 1'b0;
            drive_ready      <= 1'b1;
            attention_flag   <= 1'b0;
            tape_mark_r      <= 1'b0;
        end
        else if (clr_all)
        begin
            fmt_hold_r       <= 1'b0;
            exception_signal <= 1'b0;
            end_of_block     <= 1'b0;
            drive_ready      <= 1'b1;
            attention_flag   <= 1'b0;
            tape_mark_r      <= 1'b0;
        end
        else
        begin
            // tape mark status holds until the next transfer starts or a drive clear or bus init
            if (!pe_mode && nrz_bad_mark)
                tape_mark_r <= 1'b1;
            else if (start_xfer)
                tape_mark_r <= 1'b0;
            if (start_xfer && bad_fmt)
            begin
                fmt_hold_r       <= 1'b1;
                exception_signal <= 1'b1;
                end_of_block     <= 1'b1;
                drive_ready      <= 1'b0;
            end
            // end of block lasts one cycle, then ready and attention rise
            else if (end_of_block)
            begin
                end_of_block   <= 1'b0;
                drive_ready    <= 1'b1;
                attention_flag <= 1'b1;
                fmt_hold_r     <= 1'b0;
            end
            else if (start_xfer || cs1_go_wr)
            begin
                drive_ready      <= 1'b0;
                exception_signal <= 1'b0;
            end
            else if (op_end)
                drive_ready <= 1'b1;
            if (wr_ok && (reg_addr == `TFE_A_ATTN) && reg_wdata[`TFE_ATTN_CLR])
                attention_flag <= 1'b0;
        end
    end

    // ==========================================================
    // drive status word, one field per bit
    always @*
    begin
        stat_word = `TFE_ZERO16;
        stat_word[`TFE_ST_ATTN]  = attention_flag;
        stat_word[`TFE_ST_ERR]   = class_a_err | class_b_err;
        stat_word[`TFE_ST_READY] = drive_ready;
        stat_word[`TFE_ST_TMARK] = tape_mark_r;
    end

    // ==========================================================
    // read data, zeros for nonexistent registers
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= `TFE_ZERO16;
        else if (reg_rd)
        begin
            case (reg_addr)
                `TFE_A_CS1:  reg_rdata <= cs1_r;
                `TFE_A_STAT: reg_rdata <= stat_word;
                `TFE_A_ERR:  reg_rdata <= {5'h00, flags};
                `TFE_A_MNT:  reg_rdata <= mnt_r;
                `TFE_A_ATTN: reg_rdata <= {15'h0000, attention_flag};
                `TFE_A_FC:   reg_rdata <= fc_r;
                `TFE_A_CS2:  reg_rdata <= cs2_r;
                `TFE_A_TC:   reg_rdata <= tc_r;
                default:     reg_rdata <= `TFE_ZERO16;
            endcase
        end
    end
endmodule // tfe_error_flags

`default_nettype wire

// ==== verification/tfe_error_flags_props.sv ====
// concurrent checks on the error flag block ports
`timescale 1ns/1ps
`default_nettype none
`include "tfe_map.vh"

module tfe_error_flags_props
(
    // clock, reset and register bus
    input wire        clk_sys, rst_b, reg_wr, reg_rd, reg_ctl_par_err,
    input wire [4:0]  reg_addr,
    input wire [15:0] reg_wdata, reg_rdata,
    // line inputs
    input wire        bus_init, run_req, pe_mode, pe_skew_corr, nrz_bad_mark,
    input wire        space_done, frame_cnt_zero, xfer_done, gap_chars_seen,
    input wire        pe_bad_amble, nrz_lrc_mismatch, pe_multi_dead,
    input wire        pe_par_no_dead, pe_skew_ovf, nrz_vert_par, nrz_late_data,
    input wire        data_par_err, xfer_busy, write_op, read_op, op_end,
    // drive control outputs
    input wire        go_bit, motion_inhibit, exception_signal, end_of_block,
    input wire        drive_ready, attention_flag, class_a_err, class_b_err,
    input wire [4:0]  func_code,
    input wire [10:0] drive_error_flags
);
    // ==========================================
    // decode helpers
    wire known_a = reg_addr inside {`TFE_A_CS1, `TFE_A_STAT, `TFE_A_ERR,
        `TFE_A_MNT, `TFE_A_ATTN, `TFE_A_FC, `TFE_A_CS2, `TFE_A_TC};
    wire fn_ok = reg_wdata[5:1] inside {`TFE_FN_NOP, `TFE_FN_CLR,
        `TFE_FN_SPF, `TFE_FN_SPR, `TFE_FN_WR, `TFE_FN_RDF};
    wire cs1_wr = reg_wr && reg_addr == `TFE_A_CS1;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // ==========================================
    // format fault steps
    sequence s_fmt_hold;
        end_of_block && exception_signal && motion_inhibit;
    endsequence
    sequence s_fmt_done;
        !end_of_block && drive_ready && attention_flag;
    endsequence

    a_bad_reg_read: assert property (reg_rd && !known_a |=>
        reg_rdata == 16'h0000 && drive_error_flags[1]) else $error("bad read");
    a_write_refused: assert property (reg_wr && go_bit && known_a && !op_end
        && !(reg_addr inside {`TFE_A_MNT, `TFE_A_ATTN})
        |=> drive_error_flags[2] && go_bit) else $error("refusal missed");
    a_ctl_par_flag: assert property (reg_wr && reg_ctl_par_err |=>
        drive_error_flags[3]) else $error("control parity flag missed");
    a_ctl_par_no_go: assert property (cs1_wr && reg_ctl_par_err
        && !go_bit |=> !go_bit) else $error("go set despite parity error");
    a_bad_func: assert property (cs1_wr && !go_bit && reg_wdata[0]
        && !reg_ctl_par_err && !fn_ok |=> drive_error_flags[0])
        else $error("bad function flag missed");
    a_fmt_steps: assert property ($rose(drive_error_flags[4]) |->
        s_fmt_hold ##1 s_fmt_done) else $error("format fault steps wrong");
    a_run_past_eob: assert property (run_req && end_of_block |=>
        drive_error_flags[9]) else $error("frame count fault missed");
    a_class_a_sum: assert property (class_a_err ==
        |(drive_error_flags & 11'h3ee)) else $error("class a wrong");
    a_class_b_sum: assert property (class_b_err ==
        |(drive_error_flags & 11'h011)) else $error("class b wrong");
    a_flags_stick: assert property (!bus_init && !cs1_wr |=>
        (drive_error_flags & $past(drive_error_flags))
        == $past(drive_error_flags)) else $error("flag dropped");
endmodule // tfe_error_flags_props
`default_nettype wire

// ==== verification/tfe_host_model.sv ====
// host controller model driving the drive control bus
`timescale 1ns/1ps
`default_nettype none

module tfe_host_model
(
    // clock and drive status
    input  wire         clk_sys,
    input  wire         end_of_block,
    input  wire         run_on,
    input  wire         run_stuck,
    input  wire  [15:0] reg_rdata,
    // control bus
    output logic [4:0]  reg_addr,
    output logic        reg_wr,
    output logic        reg_rd,
    output logic [15:0] reg_wdata,
    output logic        reg_ctl_par_err,
    output wire         run_req
);
    // run dropped as soon as end of block shows, unless told to hang on
    assign run_req = run_on && !(end_of_block && !run_stuck);
    initial
    begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        reg_ctl_par_err = 1'b0;
    end
    task wr(input logic [4:0] a, input logic [15:0] d, input logic p);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_ctl_par_err <= p;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_ctl_par_err <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule // tfe_host_model
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the error flag block
`timescale 1ns/1ps
`default_nettype none
`include "tfe_map.vh"

module testbench;
    logic        clk_sys = 1'b0, rst_b = 1'b0, bus_init = 1'b0;
    logic        pe_mode = 1'b0, frame_cnt_zero = 1'b1, gap_chars_seen = 1'b0;
    logic        write_op = 1'b0, read_op = 1'b0, op_end = 1'b0;
    logic        run_on = 1'b0, run_stuck = 1'b0;
    logic [11:0] ev = 12'h000;
    logic [15:0] rv;
    wire         xfer_busy = 1'b0;
    wire         pe_skew_corr, nrz_bad_mark, space_done, xfer_done;
    wire         pe_bad_amble, nrz_lrc_mismatch, pe_multi_dead, pe_par_no_dead;
    wire         pe_skew_ovf, nrz_vert_par, nrz_late_data, data_par_err;
    wire         reg_wr, reg_rd, reg_ctl_par_err, go_bit, motion_inhibit;
    wire         exception_signal, end_of_block, drive_ready, attention_flag;
    wire         class_a_err, class_b_err, run_req;
    wire [4:0]   reg_addr, func_code;
    wire [15:0]  reg_wdata, reg_rdata;
    wire [10:0]  drive_error_flags;
    int          bad_count = 0;
    int          n_tests = 0;
    // flag hit by each condition, and which ones need phase-encoded mode
    bit [3:0]    eb [12] = '{4'd10, 4'd10, 4'd9, 4'd8, 4'd7, 4'd7, 4'd6,
                             4'd6, 4'd6, 4'd6, 4'd6, 4'd5};
    logic [11:0] pe_sel = 12'h8b8;

    assign {pe_skew_corr, nrz_bad_mark, space_done, xfer_done, pe_bad_amble,
            nrz_lrc_mismatch, pe_multi_dead, pe_par_no_dead, pe_skew_ovf,
            nrz_vert_par, nrz_late_data, data_par_err} = ev;
    always #5 clk_sys = ~clk_sys;
    tfe_error_flags tfe_error_flags_i (.*);
    tfe_host_model tfe_host_model_i (.*);

    // ==========================================
    // helpers
    task chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task rd_chk(input logic [4:0] a, input logic [15:0] e);
        tfe_host_model_i.rd(a, rv);
        chk(rv, e);
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // end any operation, then drive clear must empty the flags
    task end_op_clear;
        tick(1);
        op_end <= 1'b1;
        tick(1);
        op_end <= 1'b0;
        tfe_host_model_i.wr(`TFE_A_CS1, 16'h0009, 1'b0);
        rd_chk(`TFE_A_ERR, 16'h0000);
    endtask
    task end_sim;
        $display("counts: %0d compares, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================
    // tests
    initial
    begin
        tick(2);
        rst_b <= 1'b1;
        read_op <= 1'b1;
        frame_cnt_zero <= 1'b0;
        gap_chars_seen <= 1'b1;
        rd_chk(`TFE_A_ERR, 16'h0000);
        for (int i = 0; i < 12; i++)
        begin
            tick(1);
            pe_mode <= pe_sel[11 - i];
            write_op <= (i == 11);
            tick(1);
            ev <= 12'h800 >> i;
            tick(1);
            ev <= 12'h000;
            tick(3);
            rd_chk(`TFE_A_ERR, 16'h0001 << eb[i]);
            tfe_host_model_i.rd(`TFE_A_STAT, rv);
            if (i == 1)
                chk({15'h0000, rv[`TFE_ST_TMARK]}, 16'h0001);
            end_op_clear;
        end
        read_op <= 1'b0;
        write_op <= 1'b0;
        $display("test done: datapath conditions");
        tfe_host_model_i.wr(5'h1f, 16'hffff, 1'b0);
        rd_chk(5'h07, 16'h0000);
        rd_chk(`TFE_A_ERR, 16'h0002);
        end_op_clear;
        tfe_host_model_i.wr(`TFE_A_CS2, 16'h0010, 1'b0);
        tfe_host_model_i.wr(`TFE_A_CS2, 16'h0000, 1'b0);
        rd_chk(`TFE_A_ERR, 16'h0028);
        end_op_clear;
        $display("test done: bad register and parity test");
        tfe_host_model_i.wr(`TFE_A_FC, 16'h1234, 1'b1);
        rd_chk(`TFE_A_FC, 16'h1234);
        tfe_host_model_i.wr(`TFE_A_CS1, 16'h0031, 1'b1);
        #1;
        chk({15'h0000, go_bit}, 16'h0000);
        chk({11'h000, func_code}, 16'h0018);
        rd_chk(`TFE_A_ERR, 16'h0008);
        end_op_clear;
        $display("test done: control parity");
        for (int k = 0; k < 2; k++)
        begin
            tick(1);
            run_on <= 1'b1;
            run_stuck <= (k == 1);
            tfe_host_model_i.wr(`TFE_A_TC, 16'h0000, 1'b0);
            tfe_host_model_i.wr(`TFE_A_CS1, 16'h0031, 1'b0);
            tick(3);
            chk({14'h0000, drive_ready, attention_flag}, 16'h0003);
            rd_chk(`TFE_A_ERR, (k == 1) ? 16'h0210 : 16'h0010);
            tfe_host_model_i.wr(`TFE_A_ATTN, 16'h0001, 1'b0);
            run_on <= 1'b0;
            end_op_clear;
        end
        $display("test done: format fault");
        tfe_host_model_i.wr(`TFE_A_TC, 16'h00c0, 1'b0);
        tfe_host_model_i.wr(`TFE_A_CS1, 16'h0031, 1'b0);
        tfe_host_model_i.wr(`TFE_A_TC, 16'h0000, 1'b0);
        tfe_host_model_i.wr(`TFE_A_MNT, 16'h0000, 1'b0);
        rd_chk(`TFE_A_ERR, 16'h0004);
        end_op_clear;
        tfe_host_model_i.wr(`TFE_A_CS1, 16'h0031, 1'b0);
        rd_chk(`TFE_A_ERR, 16'h0000);
        end_op_clear;
        $display("test done: refused writes");
        tfe_host_model_i.wr(`TFE_A_CS1, 16'h0005, 1'b0);
        rd_chk(`TFE_A_ERR, 16'h0001);
        tick(1);
        bus_init <= 1'b1;
        tick(1);
        bus_init <= 1'b0;
        rd_chk(`TFE_A_ERR, 16'h0000);
        $display("test done: bad function and bus init");
        end_sim;
    end

    // watchdog
    initial
    begin
        #100000;
        bad_count++;
        end_sim;
    end
endmodule // testbench

bind tfe_error_flags tfe_error_flags_props tfe_error_flags_props_i (.*);
`default_nettype wire
